// ### inc/core_map.vh
/*
  Constants for the processor core registers and flags block: reset values,
  vectors, opcodes, addressing-mode nibbles, flag positions and APB offsets.
  Assumes it is included by bare name from the design file.
*/
`ifndef CORE_MAP_VH
`define CORE_MAP_VH

`define STACK_RESET 16'h00FF
`define STACK_LO_FF 8'hFF
`define PROG_RESET 16'h0000
`define VEC_RESET 16'hFFFE
`define VEC_SWINT 16'hFFFC
`define VEC_SWINT_MON 16'hFEFC
`define VEC_IRQ_TOP 16'hFFFA
`define PAGE_ZERO 8'h00

`define OP_PREFIX 8'h9E
`define OP_ADD_SIG_STK 8'hA7
`define OP_ADD_SIG_IDX 8'hAF
`define OP_BR_CARRY_CLR 8'h24
`define OP_BR_CARRY_SET 8'h25
`define OP_BR_NOT_ZERO 8'h26
`define OP_BR_ZERO 8'h27
`define OP_BR_SGE 8'h90
`define OP_BR_SLT 8'h91
`define OP_BR_SGT 8'h92
`define OP_BR_SLE 8'h93
`define OP_RET_INT 8'h80
`define OP_SW_INT 8'h83
`define OP_PULL_HI 8'h8A
`define OP_PUSH_HI 8'h8B
`define OP_STOP 8'h8E
`define OP_WAIT 8'h8F
`define OP_MASK_CLR 8'h9A
`define OP_MASK_SET 8'h9B
`define OP_STK_LO_RESET 8'h9C
`define OP_DEC_ADJ 8'h72

`define ALU_AND 4'h4
`define ALU_ADC 4'h9
`define ALU_ADD 4'hB
`define MODE_IMM 4'hA
`define MODE_DIR 4'hB
`define MODE_EXT 4'hC
`define MODE_IX2 4'hD
`define MODE_IX1 4'hE
`define MODE_IX 4'hF

`define F_C 0
`define F_Z 1
`define F_N 2
`define F_I 3
`define F_H 4
`define F_V 7
`define FLAGS_ONES 2'b11

`define STK_LAST 3'h4
`define STK_FLAGS 3'h0
`define STK_ACC 3'h1
`define STK_IDX_LO 3'h2
`define STK_PROG_HI 3'h3

`define BCD_NINE 4'h9
`define BCD_MAX 8'h99
`define DAA_LO_COR 8'h06
`define DAA_HI_COR 8'h60

`define STAB_DEFAULT 13'h1000

`define A_FLAGS 8'h00
`define A_ACC 8'h04
`define A_INDEX 8'h08
`define A_STACK 8'h0C
`define A_PROG 8'h10
`define A_STATUS 8'h14

`endif

// ### logic/core_regs_flags.v
/*
  8-bit processor core: accumulator, index pair, stack pointer, program
  counter, condition flags, interrupt stacking, wait/stop and break entry,
  and the add/add-carry/and, signed-add and branch instruction subset.
  Assumes an asynchronous-read byte memory on mem_* (data valid in the cycle
  the address is shown) and an APB master for the debug view of the state.
*/
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "core_map.vh"
`default_nettype none

module core_regs_flags #(
  parameter IRQ_N = 4,
  parameter [12:0] STAB_CYCLES = `STAB_DEFAULT
) (
  input wire clk,
  input wire rstn,
  output wire [15:0] mem_addr,
  output wire [7:0] mem_wdata,
  output wire mem_we,
  input wire [7:0] mem_rdata,
  input wire [IRQ_N-1:0] irq_req,
  input wire brk_en,
  input wire brk_req,
  input wire monitor_mode,
  output wire core_halted,
  output wire stop_mode,
  output wire break_active,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr
);

  localparam S_FETCH = 4'h0;
  localparam S_OP1 = 4'h1;
  localparam S_OP2 = 4'h2;
  localparam S_MEM = 4'h3;
  localparam S_BR = 4'h4;
  localparam S_PUSH = 4'h5;
  localparam S_PULL = 4'h6;
  localparam S_VHI = 4'h7;
  localparam S_VLO = 4'h8;
  localparam S_HALT = 4'h9;
  localparam S_STAB = 4'hA;

  reg [3:0] st_reg;
  reg [7:0] acc_reg, idx_hi_reg, idx_lo_reg, opc_reg, tmp_reg, wdata_reg;
  reg [15:0] stack_pointer_reg, program_counter_reg, vec_reg, addr_reg;
  reg ovf_reg, half_reg, mask_reg, neg_reg, zero_reg, carry_reg;
  reg pfx_reg, single_reg, we_reg, brk_act_reg, stop_reg;
  reg [2:0] stk_cnt_reg;
  reg [12:0] stab_reg;

  wire [15:0] idx_pair = {idx_hi_reg, idx_lo_reg};
  wire [15:0] prog_plus1 = program_counter_reg + 16'h0001;
  wire [15:0] stack_dn = stack_pointer_reg - 16'h0001;
  wire [15:0] stack_up = stack_pointer_reg + 16'h0001;
  wire [15:0] rd_sext = {{8{mem_rdata[7]}}, mem_rdata};
  wire [15:0] tmp_sext = {{8{tmp_reg[7]}}, tmp_reg};
  wire [15:0] base16 = pfx_reg ? stack_pointer_reg : idx_pair;
  wire [3:0] mode = opc_reg[7:4];
  wire [7:0] flags_rd = {ovf_reg, `FLAGS_ONES, half_reg, mask_reg, neg_reg, zero_reg, carry_reg};
  wire [15:0] swi_vec = monitor_mode ? `VEC_SWINT_MON : `VEC_SWINT;

  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_we = we_reg;
  assign core_halted = (st_reg == S_HALT) | (st_reg == S_STAB);
  assign stop_mode = stop_reg;
  assign break_active = brk_act_reg;
  assign pready = 1'b1;

  function is_alu;
    input [7:0] o;
    input p;
    begin
      is_alu = ((o[3:0] == `ALU_ADD) | (o[3:0] == `ALU_ADC) | (o[3:0] == `ALU_AND)) &
               (p ? ((o[7:4] == `MODE_IX2) | (o[7:4] == `MODE_IX1)) : (o[7:4] >= `MODE_IMM));
    end
  endfunction

  function br_ok;
    input [7:0] o;
    reg nv;
    begin
      nv = neg_reg ^ ovf_reg;
      case (o)
        `OP_BR_CARRY_CLR: br_ok = ~carry_reg;
        `OP_BR_CARRY_SET: br_ok = carry_reg;
        `OP_BR_NOT_ZERO: br_ok = ~zero_reg;
        `OP_BR_ZERO: br_ok = zero_reg;
        `OP_BR_SGE: br_ok = ~nv;
        `OP_BR_SLT: br_ok = nv;
        `OP_BR_SGT: br_ok = ~(zero_reg | nv);
        `OP_BR_SLE: br_ok = zero_reg | nv;
        default: br_ok = 1'b0;
      endcase
    end
  endfunction

  // interrupt frame order from the top: pc low, pc high, index low, acc, flags
  function [7:0] stk_byte;
    input [2:0] k;
    begin
      case (k)
        3'h0: stk_byte = program_counter_reg[7:0];
        3'h1: stk_byte = program_counter_reg[15:8];
        3'h2: stk_byte = idx_lo_reg;
        3'h3: stk_byte = acc_reg;
        default: stk_byte = flags_rd;
      endcase
    end
  endfunction

  // lowest request index has the highest priority
  integer i;
  reg irq_hit;
  reg [15:0] irq_vec;
  always @* begin
    irq_hit = 1'b0;
    irq_vec = `VEC_IRQ_TOP;
    for (i = IRQ_N - 1; i >= 0; i = i - 1) begin
      if (irq_req[i]) begin
        irq_hit = 1'b1;
        irq_vec = `VEC_IRQ_TOP - {i[14:0], 1'b0};
      end
    end
  end

  // a held break request re-enters only after the return has seen it drop
  wire brk_take = brk_en & brk_req & ~brk_act_reg;
  wire int_go = ~pfx_reg & (brk_take | (irq_hit & ~mask_reg));

  reg [8:0] sum9;
  reg [4:0] hsum;
  reg [7:0] alu_r;
  reg alu_v, alu_h, alu_c;
  wire cin = (opc_reg[3:0] == `ALU_ADC) & carry_reg;
  always @* begin
    sum9 = {1'b0, acc_reg} + {1'b0, mem_rdata} + {8'h00, cin};
    hsum = {1'b0, acc_reg[3:0]} + {1'b0, mem_rdata[3:0]} + {4'h0, cin};
    if (opc_reg[3:0] == `ALU_AND) begin
      alu_r = acc_reg & mem_rdata;
      alu_v = 1'b0;
      alu_h = half_reg;
      alu_c = carry_reg;
    end else begin
      alu_r = sum9[7:0];
      alu_v = (acc_reg[7] == mem_rdata[7]) & (sum9[7] != acc_reg[7]);
      alu_h = hsum[4];
      alu_c = sum9[8];
    end
  end

  wire do_alu = is_alu(opc_reg, pfx_reg) &
                ((st_reg == S_MEM) | ((st_reg == S_OP1) & (mode == `MODE_IMM) & ~pfx_reg));

  wire daa_hi = carry_reg | (acc_reg > `BCD_MAX);
  wire daa_lo = half_reg | (acc_reg[3:0] > `BCD_NINE);
  wire [7:0] daa_r = acc_reg + (daa_hi ? `DAA_HI_COR : 8'h00) + (daa_lo ? `DAA_LO_COR : 8'h00);

  wire flags_wr = psel & penable & pwrite & (paddr == `A_FLAGS);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= S_VHI;
      acc_reg <= 8'h00;
      idx_hi_reg <= 8'h00;
      idx_lo_reg <= 8'h00;
      stack_pointer_reg <= `STACK_RESET;
      program_counter_reg <= `PROG_RESET;
      {ovf_reg, half_reg, neg_reg, zero_reg, carry_reg} <= 5'h00;
      mask_reg <= 1'b1;
      opc_reg <= 8'h00;
      tmp_reg <= 8'h00;
      wdata_reg <= 8'h00;
      pfx_reg <= 1'b0;
      single_reg <= 1'b0;
      we_reg <= 1'b0;
      brk_act_reg <= 1'b0;
      stop_reg <= 1'b0;
      stk_cnt_reg <= 3'h0;
      stab_reg <= 13'h0000;
      vec_reg <= `VEC_RESET;
      addr_reg <= `VEC_RESET;
    end else begin
      // software may rewrite the arithmetic flags, never the mask
      if (flags_wr) begin
        ovf_reg <= pwdata[`F_V];
        half_reg <= pwdata[`F_H];
        neg_reg <= pwdata[`F_N];
        zero_reg <= pwdata[`F_Z];
        carry_reg <= pwdata[`F_C];
      end
      if (do_alu) begin
        acc_reg <= alu_r;
        ovf_reg <= alu_v;
        half_reg <= alu_h;
        carry_reg <= alu_c;
        neg_reg <= alu_r[7];
        zero_reg <= (alu_r == 8'h00);
      end
      case (st_reg)
        S_FETCH: begin
          if (int_go) begin
            vec_reg <= brk_take ? swi_vec : irq_vec;
            brk_act_reg <= brk_act_reg | brk_take;
            single_reg <= 1'b0;
            stk_cnt_reg <= 3'h0;
            we_reg <= 1'b1;
            addr_reg <= stack_pointer_reg;
            wdata_reg <= program_counter_reg[7:0];
            st_reg <= S_PUSH;
          end else begin
            opc_reg <= mem_rdata;
            // prefix must survive into the operand cycles so the stack pointer is the base
            pfx_reg <= pfx_reg & is_alu(mem_rdata, pfx_reg);
            program_counter_reg <= prog_plus1;
            addr_reg <= prog_plus1;
            if (mem_rdata == `OP_PREFIX) begin
              pfx_reg <= 1'b1;
            end else if (is_alu(mem_rdata, pfx_reg)) begin
              if ((mem_rdata[7:4] == `MODE_IX) & ~pfx_reg) begin
                addr_reg <= idx_pair;
                st_reg <= S_MEM;
              end else begin
                st_reg <= S_OP1;
              end
            end else begin
              case (mem_rdata)
                `OP_ADD_SIG_STK, `OP_ADD_SIG_IDX, `OP_BR_CARRY_CLR, `OP_BR_CARRY_SET, `OP_BR_NOT_ZERO,
                `OP_BR_ZERO, `OP_BR_SGE, `OP_BR_SLT, `OP_BR_SGT, `OP_BR_SLE: begin
                  st_reg <= S_OP1;
                end
                `OP_STK_LO_RESET: begin
                  stack_pointer_reg[7:0] <= `STACK_LO_FF;
                end
                `OP_MASK_CLR: begin
                  mask_reg <= 1'b0;
                end
                `OP_MASK_SET: begin
                  mask_reg <= 1'b1;
                end
                `OP_WAIT: begin
                  mask_reg <= 1'b0;
                  st_reg <= S_HALT;
                end
                `OP_STOP: begin
                  mask_reg <= 1'b0;
                  stop_reg <= 1'b1;
                  st_reg <= S_HALT;
                end
                `OP_SW_INT: begin
                  vec_reg <= swi_vec;
                  single_reg <= 1'b0;
                  stk_cnt_reg <= 3'h0;
                  we_reg <= 1'b1;
                  addr_reg <= stack_pointer_reg;
                  wdata_reg <= prog_plus1[7:0];
                  st_reg <= S_PUSH;
                end
                `OP_PUSH_HI: begin
                  single_reg <= 1'b1;
                  we_reg <= 1'b1;
                  addr_reg <= stack_pointer_reg;
                  wdata_reg <= idx_hi_reg;
                  st_reg <= S_PUSH;
                end
                `OP_RET_INT, `OP_PULL_HI: begin
                  single_reg <= (mem_rdata == `OP_PULL_HI);
                  stk_cnt_reg <= 3'h0;
                  stack_pointer_reg <= stack_up;
                  addr_reg <= stack_up;
                  st_reg <= S_PULL;
                end
                `OP_DEC_ADJ: begin
                  acc_reg <= daa_r;
                  carry_reg <= daa_hi;
                  neg_reg <= daa_r[7];
                  zero_reg <= (daa_r == 8'h00);
                end
                default: begin
                end
              endcase
            end
          end
        end
        S_OP1: begin
          program_counter_reg <= prog_plus1;
          addr_reg <= prog_plus1;
          st_reg <= S_FETCH;
          if (is_alu(opc_reg, pfx_reg)) begin
            if (mode == `MODE_DIR) begin
              addr_reg <= {`PAGE_ZERO, mem_rdata};
              st_reg <= S_MEM;
            end else if (mode == `MODE_IX1) begin
              addr_reg <= base16 + {8'h00, mem_rdata};
              st_reg <= S_MEM;
            end else if (mode != `MODE_IMM) begin
              tmp_reg <= mem_rdata;
              st_reg <= S_OP2;
            end
          end else if (opc_reg == `OP_ADD_SIG_STK) begin
            stack_pointer_reg <= stack_pointer_reg + rd_sext;
          end else if (opc_reg == `OP_ADD_SIG_IDX) begin
            {idx_hi_reg, idx_lo_reg} <= idx_pair + rd_sext;
          end else begin
            tmp_reg <= mem_rdata;
            st_reg <= S_BR;
          end
        end
        S_OP2: begin
          program_counter_reg <= prog_plus1;
          st_reg <= S_MEM;
          if (mode == `MODE_EXT) begin
            addr_reg <= {tmp_reg, mem_rdata};
          end else begin
            addr_reg <= base16 + {tmp_reg, mem_rdata};
          end
        end
        S_MEM: begin
          pfx_reg <= 1'b0;
          addr_reg <= program_counter_reg;
          st_reg <= S_FETCH;
        end
        S_BR: begin
          // program counter already sits two past the opcode
          st_reg <= S_FETCH;
          if (br_ok(opc_reg)) begin
            program_counter_reg <= program_counter_reg + tmp_sext;
            addr_reg <= program_counter_reg + tmp_sext;
          end else begin
            addr_reg <= program_counter_reg;
          end
        end
        S_PUSH: begin
          stack_pointer_reg <= stack_dn;
          if (single_reg | (stk_cnt_reg == `STK_LAST)) begin
            we_reg <= 1'b0;
            if (single_reg) begin
              addr_reg <= program_counter_reg;
              st_reg <= S_FETCH;
            end else begin
              // upper index byte is not part of the frame
              mask_reg <= 1'b1;
              addr_reg <= vec_reg;
              st_reg <= S_VHI;
            end
          end else begin
            stk_cnt_reg <= stk_cnt_reg + 3'h1;
            addr_reg <= stack_dn;
            wdata_reg <= stk_byte(stk_cnt_reg + 3'h1);
          end
        end
        S_PULL: begin
          if (single_reg) begin
            idx_hi_reg <= mem_rdata;
            addr_reg <= program_counter_reg;
            st_reg <= S_FETCH;
          end else begin
            case (stk_cnt_reg)
              `STK_FLAGS: begin
                ovf_reg <= mem_rdata[`F_V];
                half_reg <= mem_rdata[`F_H];
                mask_reg <= mem_rdata[`F_I];
                neg_reg <= mem_rdata[`F_N];
                zero_reg <= mem_rdata[`F_Z];
                carry_reg <= mem_rdata[`F_C];
              end
              `STK_ACC: acc_reg <= mem_rdata;
              `STK_IDX_LO: idx_lo_reg <= mem_rdata;
              `STK_PROG_HI: program_counter_reg[15:8] <= mem_rdata;
              default: begin
                program_counter_reg[7:0] <= mem_rdata;
                if (!brk_req) begin
                  brk_act_reg <= 1'b0;
                end
              end
            endcase
            if (stk_cnt_reg == `STK_LAST) begin
              addr_reg <= {program_counter_reg[15:8], mem_rdata};
              st_reg <= S_FETCH;
            end else begin
              stk_cnt_reg <= stk_cnt_reg + 3'h1;
              stack_pointer_reg <= stack_up;
              addr_reg <= stack_up;
            end
          end
        end
        S_VHI: begin
          program_counter_reg[15:8] <= mem_rdata;
          addr_reg <= vec_reg + 16'h0001;
          st_reg <= S_VLO;
        end
        S_VLO: begin
          program_counter_reg[7:0] <= mem_rdata;
          addr_reg <= {program_counter_reg[15:8], mem_rdata};
          st_reg <= S_FETCH;
        end
        S_HALT: begin
          // stop wakes only on the external request, source 0
          if (stop_reg) begin
            if (irq_req[0]) begin
              stab_reg <= STAB_CYCLES - 13'h0001;
              st_reg <= S_STAB;
            end
          end else if (irq_hit | brk_take) begin
            st_reg <= S_FETCH;
          end
        end
        S_STAB: begin
          if (stab_reg == 13'h0000) begin
            stop_reg <= 1'b0;
            st_reg <= S_FETCH;
          end else begin
            stab_reg <= stab_reg - 13'h0001;
          end
        end
        default: begin
          st_reg <= S_FETCH;
        end
      endcase
    end
  end

  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (paddr)
      `A_FLAGS: rd_mux = {24'h000000, flags_rd};
      `A_ACC: rd_mux = {24'h000000, acc_reg};
      `A_INDEX: rd_mux = {16'h0000, idx_pair};
      `A_STACK: rd_mux = {16'h0000, stack_pointer_reg};
      `A_PROG: rd_mux = {16'h0000, program_counter_reg};
      `A_STATUS: rd_mux = {29'h00000000, brk_act_reg, stop_reg, core_halted};
      default: rd_ok = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle so the access phase never waits
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~rd_ok;
    end
  end

endmodule

`default_nettype wire

// ### verif/core_regs_flags_asserts.sv
/*
  Port-level checker for core_regs_flags: reset fetch, stacking, break
  vector, halt behaviour and the APB view. Bound to every instance.
*/
`timescale 1ns/100ps
`default_nettype none
module core_regs_flags_asserts #(
  parameter IRQ_N = 4,
  parameter [12:0] STAB_CYCLES = 13'h1000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic monitor_mode,
  input wire logic core_halted,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence vec_fetch;
    !mem_we && (mem_addr == 16'hFEFC || mem_addr[15:8] == 8'hFF);
  endsequence
  sequence frame_start;
    $rose(mem_we) ##1 mem_we;
  endsequence
  reset_fetch_a: assert property (!$past(rstn) |-> mem_addr == 16'hFFFE ##1 mem_addr == 16'hFFFF)
    else $error("reset vector fetch order wrong");
  push_order_a: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("stack push address not descending");
  frame_vector_a: assert property (frame_start |-> mem_we [*4] ##1 vec_fetch)
    else $error("interrupt frame not five bytes then vector");
  flags_ones_a: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=> prdata[6:5] == 2'b11 && prdata[31:8] == 24'h000000)
    else $error("flag bits 6 and 5 not one");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  break_vector_a: assert property ($rose(break_active) |-> ##[1:8] mem_addr == (monitor_mode ? 16'hFEFC : 16'hFFFC))
    else $error("break vector address wrong");
  halt_quiet_a: assert property (core_halted |-> !mem_we)
    else $error("write while halted");
  halt_wake_a: assert property (core_halted && !stop_mode && irq_req != 0 |-> ##[1:2] !core_halted)
    else $error("wait not left on request");
  ready_high_a: assert property (psel |-> pready)
    else $error("apb not ready");
endmodule
bind core_regs_flags core_regs_flags_asserts #(.IRQ_N(IRQ_N), .STAB_CYCLES(STAB_CYCLES)) chk_i (
  .clk(clk), .rstn(rstn), .mem_addr(mem_addr), .mem_we(mem_we), .irq_req(irq_req),
  .monitor_mode(monitor_mode), .core_halted(core_halted), .stop_mode(stop_mode),
  .break_active(break_active), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### verif/core_regs_flags_tb.sv
/*
  Testbench for core_regs_flags: short programs in a bench memory, each
  ending in wait (the last one in stop), then the state is read over APB.
  Assumes async-read memory and the APB map of core_map.vh.
*/
`timescale 1ns/100ps
`include "core_map.vh"
`default_nettype none
module core_regs_flags_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] irq_req = 4'h0;
  logic brk_en = 1'b0, brk_req = 1'b0, monitor_mode = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata;
  wire mem_we, core_halted, stop_mode, break_active, pready, pslverr;
  wire [31:0] prdata;
  logic [7:0] mem [0:65535];
  int n_mismatch = 0, checked = 0, c, i;
  logic [87:0] progs [9] = '{88'hAB7FAB018F, 88'hAB80A9808F, 88'hAB80AB80A9018F, 88'hAB0FAB01A4F08F,
    88'hAB012402AB10AB208F, 88'hABFFAB012402AB10AB208F, 88'hAB80A7019CA7FEAF858F,
    88'hAF20FBBB219EEB21728F, 88'hAF858B838A8F};
  int lens [9] = '{5, 5, 7, 7, 9, 11, 10, 10, 6};
  logic [7:0] e_acc [9] = '{8'h80, 8'h00, 8'h02, 8'h10, 8'h21, 8'h30, 8'h80, 8'h57, 8'h00};
  logic [7:0] e_flg [9] = '{8'hF4, 8'hE3, 8'h60, 8'h70, 8'h60, 8'h60, 8'h64, 8'h70, 8'h60};
  logic [7:0] frame [10] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h60, 8'h02, 8'h02, 8'h00, 8'h11, 8'h68};
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
  initial begin
    forever #4 clk = ~clk;
  end
  core_regs_flags #(.IRQ_N(4), .STAB_CYCLES(13'h0004)) dut (
    .clk(clk), .rstn(rstn), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_rdata(mem_rdata), .irq_req(irq_req), .brk_en(brk_en), .brk_req(brk_req),
    .monitor_mode(monitor_mode), .core_halted(core_halted), .stop_mode(stop_mode),
    .break_active(break_active), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task chk(input [31:0] exp, input [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rdata);
  endtask
  // program is right-aligned in p; core restarts at 0100 through the vector
  task boot(input [87:0] p, input int n);
    for (i = 0; i < n; i++) mem[16'h0100 + i] = p[8*(n-1-i) +: 8];
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task wait_halt;
    int n;
    n = 0;
    while (core_halted !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(32'h1, {31'h0, core_halted});
  endtask
  task results;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
  initial begin
    mem[16'hFFFE] = 8'h01;
    mem[16'hFFFF] = 8'h00;
    // operands for the direct, indexed and stack-offset adds; software interrupt handler at 0310
    {mem[16'h0020], mem[16'h0021], mem[16'h0120]} = 24'h152319;
    {mem[16'hFFFC], mem[16'hFFFD], mem[16'h0310], mem[16'h0311], mem[16'h0312]} = 40'h0310AF7F80;
    for (c = 0; c < 9; c++) begin
      boot(progs[c], lens[c]);
      if (c == 0) rd(`A_FLAGS, 32'h68);
      if (c == 0) rd(`A_STACK, 32'h00FF);
      wait_halt;
      rd(`A_ACC, {24'h0, e_acc[c]});
      rd(`A_FLAGS, {24'h0, e_flg[c]});
      rd(`A_STACK, c == 6 ? 32'h01FD : 32'h00FF);
      rd(`A_INDEX, c == 6 || c == 8 ? 32'hFF85 : c == 7 ? 32'h0020 : 32'h0000);
    end
    // two handlers differ only in the value they leave in the accumulator
    {mem[16'hFFF8], mem[16'hFFF9], mem[16'hFFF6], mem[16'hFFF7]} = 32'h02000300;
    {mem[16'h0200], mem[16'h0201], mem[16'h0202], mem[16'h0203]} = 32'hAB1124FE;
    {mem[16'h0300], mem[16'h0301], mem[16'h0302], mem[16'h0303]} = 32'hAB2224FE;
    {mem[16'hFEFC], mem[16'hFEFD], mem[16'h0400], mem[16'h0401]} = 32'h040024FE;
    boot(88'h9A8F, 2);
    wait_halt;
    rd(`A_STATUS, 32'h1);
    rd(`A_FLAGS, 32'h60);
    irq_req <= 4'b0110;
    repeat (25) @(posedge clk);
    irq_req <= 4'h0;
    rd(`A_ACC, 32'h11);
    rd(`A_FLAGS, 32'h68);
    rd(`A_STACK, 32'h00FA);
    brk_en <= 1'b1;
    brk_req <= 1'b1;
    monitor_mode <= 1'b1;
    repeat (25) @(posedge clk);
    rd(`A_STATUS, 32'h4);
    rd(`A_STACK, 32'h00F5);
    for (c = 0; c < 10; c++) chk({24'h0, frame[c]}, {24'h0, mem[16'h00FF - c]});
    apb(1'b1, `A_FLAGS, 32'h96);
    rd(`A_FLAGS, 32'hFE);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'h1, {31'h0, err});
    chk(32'h0, rdata);
    // stop: a lower-priority request must not wake it, source 0 does after the delay
    brk_en <= 1'b0;
    {mem[16'hFFFA], mem[16'hFFFB]} = 16'h0200;
    boot(88'h9A8E, 2);
    wait_halt;
    irq_req <= 4'b0010;
    repeat (10) @(posedge clk);
    rd(`A_STATUS, 32'h3);
    rd(`A_FLAGS, 32'h60);
    irq_req <= 4'b0011;
    repeat (25) @(posedge clk);
    irq_req <= 4'h0;
    rd(`A_STATUS, 32'h0);
    rd(`A_ACC, 32'h11);
    results;
  end
endmodule
`default_nettype wire
